// File: include/exec_alu_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "skip_exec_params.svh"

interface exec_alu_if;
  import skip_exec_pkg::*;

  // Operands
  op_t op;
  byte_t work;
  byte_t mem;
  logic [`BIT_SEL_W-1:0] bit_sel;

  // Results
  byte_t result;
  flags_t flags;
  logic skip;
  logic write_work;
  logic write_mem;
  logic write_flags;

  modport core (output op, work, mem, bit_sel,
                input result, flags, skip, write_work, write_mem, write_flags);
  modport alu (input op, work, mem, bit_sel,
               output result, flags, skip, write_work, write_mem, write_flags);
endinterface

`default_nettype wire

// File: include/skip_exec_params.svh
`ifndef SKIP_EXEC_PARAMS_SVH
`define SKIP_EXEC_PARAMS_SVH

// Data and selector widths
`define BYTE_W 8
`define BIT_SEL_W 3
`define NIBBLE_W 4

// Status flag positions inside the flag vector
`define FLAG_W 6
`define FLAG_OV 0
`define FLAG_Z 1
`define FLAG_AC 2
`define FLAG_C 3
`define FLAG_SC 4
`define FLAG_CZ 5

// Reset values and byte constants
`define WORK_RST 8'h00
`define FLAGS_RST 6'h00
`define BYTE_ZERO 8'h00
`define BYTE_ONE 8'h01
`define MSB 7

`endif

// File: include/skip_exec_pkg.sv
`include "skip_exec_params.svh"

package skip_exec_pkg;

  // Instructions handled by the execute stage
  typedef enum logic [3:0] {
    NO_OP,
    LOAD_WORK,
    INCR_SKIP_TO_WORK,
    SKIP_IF_NONZERO_BIT,
    SKIP_IF_NONZERO_BYTE,
    SUBTRACT_TO_WORK,
    SUBTRACT_TO_MEMORY,
    NIBBLE_EXCHANGE_IN_PLACE,
    NIBBLE_EXCHANGE_TO_WORK
  } op_t;

  // Execute sequencing: normal issue or squashing the fetched follower
  typedef enum logic {
    RUN,
    SQUASH
  } exec_state_t;

  typedef logic [`BYTE_W-1:0] byte_t;
  typedef logic [`FLAG_W-1:0] flags_t;

endpackage

// File: rtl/exec_alu.sv
`timescale 1ns/1ps
`default_nettype none
`include "skip_exec_params.svh"

module exec_alu
  import skip_exec_pkg::*;
(
  // Operands in, results out
  exec_alu_if.alu a
);

  // Exchange the two nibbles of a byte
  function automatic byte_t nibble_swap(input byte_t v);
    nibble_swap = {v[`NIBBLE_W-1:0], v[`BYTE_W-1:`NIBBLE_W]};
  endfunction

  logic [`BYTE_W:0] wide_diff;
  logic [`NIBBLE_W:0] low_diff;
  byte_t incr;

  // Shared arithmetic
  assign wide_diff = {1'b0, a.work} - {1'b0, a.mem};
  assign low_diff = {1'b0, a.work[`NIBBLE_W-1:0]} - {1'b0, a.mem[`NIBBLE_W-1:0]};
  assign incr = a.mem + `BYTE_ONE;

  // Result, flag and skip decode per instruction
  always_comb begin
    a.result = a.work;
    a.flags = `FLAGS_RST;
    a.skip = 1'b0;
    a.write_work = 1'b0;
    a.write_mem = 1'b0;
    a.write_flags = 1'b0;
    case (a.op)
      LOAD_WORK: begin
        a.result = a.mem;
        a.write_work = 1'b1;
      end
      INCR_SKIP_TO_WORK: begin
        a.result = incr;
        a.write_work = 1'b1;
        a.skip = (incr == `BYTE_ZERO);
      end
      SKIP_IF_NONZERO_BIT: begin
        a.skip = a.mem[a.bit_sel];
      end
      SKIP_IF_NONZERO_BYTE: begin
        a.skip = (a.mem != `BYTE_ZERO);
      end
      SUBTRACT_TO_WORK, SUBTRACT_TO_MEMORY: begin
        a.result = wide_diff[`BYTE_W-1:0];
        a.write_work = (a.op == SUBTRACT_TO_WORK);
        a.write_mem = (a.op == SUBTRACT_TO_MEMORY);
        a.write_flags = 1'b1;
        a.flags[`FLAG_OV] = (a.work[`MSB] != a.mem[`MSB]) &&
                            (wide_diff[`MSB] != a.work[`MSB]);
        a.flags[`FLAG_Z] = (wide_diff[`BYTE_W-1:0] == `BYTE_ZERO);
        a.flags[`FLAG_AC] = ~low_diff[`NIBBLE_W];
        a.flags[`FLAG_C] = ~wide_diff[`BYTE_W]; // Clear on borrow
        a.flags[`FLAG_SC] = a.flags[`FLAG_OV] ^ wide_diff[`MSB];
        a.flags[`FLAG_CZ] = a.flags[`FLAG_Z];
      end
      NIBBLE_EXCHANGE_IN_PLACE: begin
        a.result = nibble_swap(a.mem);
        a.write_mem = 1'b1;
      end
      NIBBLE_EXCHANGE_TO_WORK: begin
        a.result = nibble_swap(a.mem);
        a.write_work = 1'b1;
      end
      default: begin
        a.result = a.work;
      end
    endcase
  end

endmodule

`default_nettype wire

// File: rtl/skip_subtract_swap_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "skip_exec_params.svh"

// Operation
// - Increment-skip: working register gets byte plus one; skip when that is zero.
// - A taken skip turns the fetched follower into a dummy cycle.
// - Bit skip: skip when selected bit is one; flags untouched.
// - Byte skip: skip when byte is non-zero; flags and memory untouched.
// - Subtract-to-work: working register minus byte into working register, six flags.
// - Subtract carry flag is zero on borrow, one otherwise.
// - Subtract-to-memory: difference written back to the byte, same six flags.
// - In-place swap exchanges byte nibbles into memory; flags untouched.
// - Swap-to-work loads swapped byte into working register; memory, flags untouched.
module skip_subtract_swap_exec
  import skip_exec_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Instruction issue from the fetch stage
  input wire logic issue_valid,
  input wire op_t issue_op,
  input wire logic [`BYTE_W-1:0] issue_mem,
  input wire logic [`BIT_SEL_W-1:0] issue_bit,
  // Architectural state
  output logic [`BYTE_W-1:0] working_register_q,
  output logic [`FLAG_W-1:0] flags_q,
  // Data memory write-back
  output logic mem_wr_en_q,
  output logic [`BYTE_W-1:0] mem_wr_data_q,
  // Sequencing status
  output logic skip_q,
  output logic dummy_q
);

  exec_alu_if alu_bus ();

  exec_state_t state_q;
  exec_state_t state_d;
  byte_t work_d;
  flags_t flags_d;
  logic mem_wr_en_d;
  byte_t mem_wr_data_d;
  logic skip_d;
  logic dummy_d;
  logic live;

  // Operand hookup to the combinational datapath
  assign alu_bus.op = issue_op;
  assign alu_bus.work = working_register_q;
  assign alu_bus.mem = issue_mem;
  assign alu_bus.bit_sel = issue_bit;

  exec_alu u_alu (
    .a(alu_bus.alu)
  );

  // An issued instruction executes only when no skip is pending
  assign live = issue_valid && (state_q == RUN);

  // Next state of the sequencer and architectural registers
  always_comb begin
    state_d = state_q;
    work_d = working_register_q;
    flags_d = flags_q;
    mem_wr_en_d = 1'b0;
    mem_wr_data_d = mem_wr_data_q;
    skip_d = 1'b0;
    dummy_d = 1'b0;
    case (state_q)
      RUN: begin
        if (live) begin
          if (alu_bus.write_work) begin
            work_d = alu_bus.result;
          end
          if (alu_bus.write_flags) begin
            flags_d = alu_bus.flags;
          end
          if (alu_bus.write_mem) begin
            mem_wr_en_d = 1'b1;
            mem_wr_data_d = alu_bus.result;
          end
          if (alu_bus.skip) begin
            skip_d = 1'b1; // Decided in the execute cycle
            state_d = SQUASH;
          end
        end
      end
      SQUASH: begin
        // Follower is consumed as a dummy cycle with no writes
        if (issue_valid) begin
          dummy_d = 1'b1;
          state_d = RUN;
        end
      end
      default: begin
        state_d = RUN;
      end
    endcase
  end

  // Register stage
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= RUN;
      working_register_q <= `WORK_RST;
      flags_q <= `FLAGS_RST;
      mem_wr_en_q <= 1'b0;
      mem_wr_data_q <= `BYTE_ZERO;
      skip_q <= 1'b0;
      dummy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      working_register_q <= work_d;
      flags_q <= flags_d;
      mem_wr_en_q <= mem_wr_en_d;
      mem_wr_data_q <= mem_wr_data_d;
      skip_q <= skip_d;
      dummy_q <= dummy_d;
    end
  end

  // Reference values seen only by the checks below
  byte_t chk_diff;
  byte_t chk_incr;
  byte_t chk_swap;
  logic chk_no_borrow;
  logic chk_bit;
  logic is_sub;

  assign chk_diff = working_register_q - issue_mem;
  assign chk_incr = issue_mem + `BYTE_ONE;
  assign chk_swap = {issue_mem[`NIBBLE_W-1:0], issue_mem[`BYTE_W-1:`NIBBLE_W]};
  assign chk_no_borrow = (working_register_q >= issue_mem);
  assign chk_bit = issue_mem[issue_bit];
  assign is_sub = (issue_op == SUBTRACT_TO_WORK) || (issue_op == SUBTRACT_TO_MEMORY);

  default clocking cb @(posedge ref_clk);
  endclocking

  default disable iff (sys_rst);

  // Skip taken, then the next issued word is squashed
  sequence s_skip_taken;
    skip_q && (state_q == SQUASH);
  endsequence

  sequence s_follower_arrives;
    (state_q == SQUASH) && issue_valid;
  endsequence

  // Idle cycles while a squash is pending
  sequence s_squash_idle;
    (state_q == SQUASH) && !issue_valid;
  endsequence

  a_incr_to_work: assert property (
    live && issue_op == INCR_SKIP_TO_WORK |=>
      working_register_q == $past(chk_incr) && !mem_wr_en_q &&
      skip_q == ($past(chk_incr) == `BYTE_ZERO))
    else $error("increment-skip result or skip wrong");

  a_skip_arms_squash: assert property (
    live && alu_bus.skip |=> s_skip_taken)
    else $error("taken skip did not arm squash");

  a_follower_dummy: assert property (
    s_follower_arrives |=> dummy_q && !mem_wr_en_q && !skip_q &&
      $stable(working_register_q) && $stable(flags_q) && state_q == RUN)
    else $error("squashed follower had side effects");

  a_bit_skip: assert property (
    live && issue_op == SKIP_IF_NONZERO_BIT |=>
      skip_q == $past(chk_bit) && $stable(flags_q) && !mem_wr_en_q)
    else $error("bit skip decision wrong");

  a_byte_skip: assert property (
    live && issue_op == SKIP_IF_NONZERO_BYTE |=>
      skip_q == ($past(issue_mem) != `BYTE_ZERO) && $stable(flags_q) && !mem_wr_en_q)
    else $error("byte skip decision wrong");

  a_sub_to_work: assert property (
    live && issue_op == SUBTRACT_TO_WORK |=>
      working_register_q == $past(chk_diff) && !mem_wr_en_q &&
      flags_q[`FLAG_Z] == (working_register_q == `BYTE_ZERO))
    else $error("subtract to work result wrong");

  a_sub_carry: assert property (
    live && is_sub |=> flags_q[`FLAG_C] == $past(chk_no_borrow))
    else $error("subtract carry flag wrong");

  a_sub_to_mem: assert property (
    live && issue_op == SUBTRACT_TO_MEMORY |=>
      mem_wr_en_q && mem_wr_data_q == $past(chk_diff) && $stable(working_register_q) &&
      flags_q[`FLAG_Z] == (mem_wr_data_q == `BYTE_ZERO))
    else $error("subtract to memory result wrong");

  a_swap_in_place: assert property (
    live && issue_op == NIBBLE_EXCHANGE_IN_PLACE |=>
      mem_wr_en_q && mem_wr_data_q == $past(chk_swap) && $stable(flags_q))
    else $error("in-place swap wrong");

  a_swap_to_work: assert property (
    live && issue_op == NIBBLE_EXCHANGE_TO_WORK |=>
      working_register_q == $past(chk_swap) && !mem_wr_en_q && $stable(flags_q))
    else $error("swap to work wrong");

  // Idle cycles keep the squash armed and change nothing
  a_squash_holds: assert property (
    s_squash_idle |=> state_q == SQUASH && !dummy_q && !mem_wr_en_q && !skip_q &&
      $stable(working_register_q) && $stable(flags_q))
    else $error("idle cycle consumed the pending squash");

  // The dummy cycle stands alone and only follows a squash
  a_dummy_alone: assert property (
    dummy_q |-> !skip_q && !mem_wr_en_q && $past(state_q) == SQUASH)
    else $error("dummy cycle overlapped other activity");

  // Memory is written only by the two memory-destination instructions
  a_mem_write_source: assert property (
    mem_wr_en_q |-> $past(live) &&
      ($past(issue_op) == SUBTRACT_TO_MEMORY || $past(issue_op) == NIBBLE_EXCHANGE_IN_PLACE))
    else $error("memory written by a non-memory instruction");

  // Synchronous reset returns every output to idle
  a_reset_clears: assert property (disable iff (1'b0)
    sys_rst |=> working_register_q == `WORK_RST && flags_q == `FLAGS_RST && !mem_wr_en_q &&
      mem_wr_data_q == `BYTE_ZERO && !skip_q && !dummy_q && state_q == RUN)
    else $error("reset did not clear outputs");

endmodule

`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import skip_exec_pkg::*;

  logic ref_clk, sys_rst, issue_valid;
  op_t issue_op;
  byte_t issue_mem, working_register_q, mem_wr_data_q;
  logic [2:0] issue_bit;
  flags_t flags_q;
  logic mem_wr_en_q, skip_q, dummy_q;
  int failures, comparisons;
  // Reference state of the bench
  byte_t w, wd;
  flags_t f;
  logic pend, we, sk, du;

  skip_subtract_swap_exec u_skip_subtract_swap_exec (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .issue_valid(issue_valid),
    .issue_op(issue_op), .issue_mem(issue_mem), .issue_bit(issue_bit),
    .working_register_q(working_register_q), .flags_q(flags_q),
    .mem_wr_en_q(mem_wr_en_q), .mem_wr_data_q(mem_wr_data_q),
    .skip_q(skip_q), .dummy_q(dummy_q));

  // Free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Flags expected after working register minus byte
  function automatic flags_t sub_flags(byte_t a, byte_t m);
    byte_t r;
    logic ov;
    flags_t x;
    r = a - m;
    ov = (a[7] != m[7]) && (r[7] != a[7]);
    x[0] = ov;
    x[1] = (r == 8'h00);
    x[2] = (a[3:0] >= m[3:0]);
    x[3] = (a >= m);
    x[4] = ov ^ r[7];
    x[5] = (r == 8'h00);
    return x;
  endfunction

  function automatic byte_t swap(byte_t m);
    return {m[3:0], m[7:4]};
  endfunction

  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic check_all();
    chk("work", working_register_q, w);
    chk("flags", {2'b00, flags_q}, {2'b00, f});
    chk("mem_we", {7'h00, mem_wr_en_q}, {7'h00, we});
    chk("mem_wd", mem_wr_data_q, wd);
    chk("skip", {7'h00, skip_q}, {7'h00, sk});
    chk("dummy", {7'h00, dummy_q}, {7'h00, du});
  endtask

  // Update the reference for one issued cycle
  task automatic model(logic v, op_t op, byte_t m, logic [2:0] b);
    we = 1'b0;
    sk = 1'b0;
    du = 1'b0;
    if (v && pend) begin
      pend = 1'b0;
      du = 1'b1;
    end else if (v) begin
      case (op)
        LOAD_WORK: w = m;
        INCR_SKIP_TO_WORK: begin
          w = m + 8'h01;
          sk = (w == 8'h00);
        end
        SKIP_IF_NONZERO_BIT: sk = m[b];
        SKIP_IF_NONZERO_BYTE: sk = (m != 8'h00);
        SUBTRACT_TO_WORK: begin
          f = sub_flags(w, m);
          w = w - m;
        end
        SUBTRACT_TO_MEMORY: begin
          f = sub_flags(w, m);
          wd = w - m;
          we = 1'b1;
        end
        NIBBLE_EXCHANGE_IN_PLACE: begin
          wd = swap(m);
          we = 1'b1;
        end
        NIBBLE_EXCHANGE_TO_WORK: w = swap(m);
        default: ;
      endcase
      pend = sk;
    end
  endtask

  // Drive one cycle at the falling edge, check one cycle later
  task automatic step(logic v, op_t op, byte_t m, logic [2:0] b);
    issue_valid = v;
    issue_op = op;
    issue_mem = m;
    issue_bit = b;
    @(posedge ref_clk);
    @(negedge ref_clk);
    model(v, op, m, b);
    check_all();
  endtask

  task automatic do_reset(int n);
    sys_rst = 1'b1;
    issue_valid = 1'b0;
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    w = 8'h00;
    wd = 8'h00;
    f = 6'h00;
    pend = 1'b0;
    {we, sk, du} = 3'b000;
    check_all();
  endtask

  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hung run, about 5000 cycles against some 700 expected
  initial begin
    #200000;
    failures++;
    finish_test();
  end

  initial begin
    failures = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    issue_valid = 1'b0;
    issue_op = NO_OP;
    issue_mem = 8'h00;
    issue_bit = 3'h0;
    void'($urandom(32'h1E46));
    do_reset(4);
    // Subtract walk, borrow and zero boundaries
    step(1'b1, LOAD_WORK, 8'h05, 3'h0);
    step(1'b1, SUBTRACT_TO_WORK, 8'h07, 3'h0);
    step(1'b1, SUBTRACT_TO_WORK, 8'hFE, 3'h0);
    step(1'b1, LOAD_WORK, 8'h80, 3'h0);
    step(1'b1, SUBTRACT_TO_MEMORY, 8'h01, 3'h0);
    step(1'b1, SUBTRACT_TO_MEMORY, 8'h80, 3'h0);
    // Taken skip squashes a write, an idle cycle in between
    step(1'b1, INCR_SKIP_TO_WORK, 8'hFF, 3'h0);
    step(1'b0, NO_OP, 8'h00, 3'h0);
    step(1'b1, SUBTRACT_TO_MEMORY, 8'h33, 3'h0);
    step(1'b1, NIBBLE_EXCHANGE_IN_PLACE, 8'hA5, 3'h0);
    step(1'b1, INCR_SKIP_TO_WORK, 8'hFE, 3'h0);
    // Every bit position, set and clear
    for (int i = 0; i < 8; i++) begin
      step(1'b1, SKIP_IF_NONZERO_BIT, 8'h01 << i, 3'(i));
      step(1'b1, NIBBLE_EXCHANGE_TO_WORK, 8'h3C, 3'h0);
      step(1'b1, SKIP_IF_NONZERO_BIT, ~(8'h01 << i), 3'(i));
    end
    step(1'b1, SKIP_IF_NONZERO_BYTE, 8'h00, 3'h0);
    step(1'b1, SKIP_IF_NONZERO_BYTE, 8'h80, 3'h0);
    step(1'b1, SKIP_IF_NONZERO_BYTE, 8'h01, 3'h0);
    // Reset while a squash is pending clears it
    step(1'b1, SKIP_IF_NONZERO_BYTE, 8'h01, 3'h0);
    do_reset(2);
    step(1'b1, NIBBLE_EXCHANGE_TO_WORK, 8'h12, 3'h0);
    // Random traffic
    for (int i = 0; i < 600; i++) begin
      step(($urandom_range(0, 9) != 0), op_t'($urandom_range(0, 8)),
           byte_t'($urandom), 3'($urandom));
    end
    finish_test();
  end
endmodule

`default_nettype wire
